// File: logic/facs_pkg.sv
package facs_pkg;
  // Timing base
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned RESTART_S = 10;
  localparam int unsigned RESTART_CYC = RESTART_S * CLK_HZ;
  localparam int unsigned DEBOUNCE_MS = 20;
  localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_MS * CLK_HZ + 999) / 1000;
  localparam int unsigned FLASH_MS = 500;
  localparam int unsigned FLASH_CYC = FLASH_MS * CLK_HZ / 1000;

  // Station addresses
  typedef logic [6:0] facs_addr_t;
  localparam facs_addr_t ADDR_DEFAULT = 7'h7e;
  localparam facs_addr_t ADDR_MAX_VALID = 7'h7d;

  // Identification number selectors
  localparam logic [7:0] SEL_MAKER = 8'h01;
  localparam logic [7:0] SEL_PROF4 = 8'h00;
  localparam logic [7:0] SEL_PROF1 = 8'h81;
  localparam logic [7:0] SEL_PROF2 = 8'h82;

  typedef enum logic [1:0] {
    FACS_LAYOUT_MAKER = 2'h0,
    FACS_LAYOUT_PROF4 = 2'h1,
    FACS_LAYOUT_PROF1 = 2'h2,
    FACS_LAYOUT_PROF2 = 2'h3
  } facs_layout_t;

  typedef enum logic [1:0] {
    FACS_UNIT_K = 2'h0,
    FACS_UNIT_F = 2'h1,
    FACS_UNIT_C = 2'h2,
    FACS_UNIT_PCT = 2'h3
  } facs_unit_t;

  // Restart sequencer, Gray coded except the RESTART to IDLE step
  typedef enum logic [1:0] {
    FACS_ST_IDLE = 2'b00,
    FACS_ST_WAIT = 2'b01,
    FACS_ST_RESTART = 2'b11
  } facs_state_t;

  // Register offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_SLAVE_ADD = 8'h04;
  localparam logic [7:0] REG_IDENT = 8'h08;
  localparam logic [7:0] REG_DISP_VAL = 8'h0c;
  localparam logic [7:0] REG_DISP_CFG = 8'h10;
  localparam logic [7:0] REG_PARAM = 8'h14;

  // Status fields
  localparam int STAT_ADDR_LSB = 0;
  localparam int STAT_MODE_BIT = 8;
  localparam int STAT_VALID_BIT = 9;
  localparam int STAT_PEND_BIT = 10;
  localparam int STAT_LOCK_BIT = 11;
  localparam int STAT_SIM_BIT = 12;
  localparam int STAT_REFUSED_BIT = 13;
  localparam int STAT_BLOCKED_BIT = 14;
  localparam int STAT_LAYOUT_LSB = 16;

  // Display configuration fields
  localparam int CFG_PCT_LSB = 0;
  localparam int CFG_UNDER_BIT = 8;
  localparam int CFG_OVER_BIT = 9;
  localparam int CFG_UNIT_LSB = 10;
  localparam int CFG_ERR_BIT = 12;
  localparam int CFG_WARN_BIT = 13;
  localparam int CFG_CHAN_LSB = 14;
  localparam int CFG_DIAG_LSB = 16;

  // Bar graph
  localparam int BAR_SEGS = 10;
  localparam int BAR_STEP_PCT = 10;

  // Switch vector: address weights 1..64, then mode, lock, simulation
  localparam int SW_W = 10;
  localparam int SW_SOFT_BIT = 7;
  localparam int SW_LOCK_BIT = 8;
  localparam int SW_SIM_BIT = 9;
  localparam logic [9:0] SW_RESET = 10'h080;

  // Reset values
  localparam logic [7:0] SEL_RESET = SEL_MAKER;
  localparam logic [15:0] PARAM_RESET = 16'h0000;
endpackage

// File: logic/facs_config_select.sv
`timescale 1ns/1ps
// Overview of operation
// - Hardware address is the sum of weights 1..64 of switches set ON.
// - Only addresses 0..125 are valid; others flagged invalid and refused by telegram, but a switch address is taken unchecked.
// - Address 126 is reserved for commissioning, not an operating address.
// - Reset state: address 126 with software addressing selected.
// - Mode switch ON to OFF: restart 10 s later with switch address.
// - Hardware addressing refuses address change telegrams.
// - Mode switch OFF to ON: restart 10 s later with address 126.
// - Software addressing accepts a new address from the change telegram.
// - Switch ON enables its function; write lock ON blocks parameter writes.
// - Simulation switch has no effect on behaviour.
// - Bar graph in 10% steps with underrange and overrange indicators.
// - Bar graph flashes while an error is present.
// - Caution symbol lit while an error or warning is active.
// - Numeric field shows value, or diagnostics during error or warning.
// - During error or warning show channel, blank when channel unknown.
// - Communication symbol only while bus communication is active.
// - Lock symbol while hardware write lock is set.
// - Selectors 1, 0, 129, 130 pick maker, four, one, two input layouts.
// - Reset selector is the maker-specific layout.
// - Unit indicator shows kelvin, Fahrenheit, Celsius or percent.
module facs_config_select #(
  parameter int unsigned RESTART_CYCLES = facs_pkg::RESTART_CYC,
  parameter int unsigned DEBOUNCE_CYCLES = facs_pkg::DEBOUNCE_CYC,
  parameter int unsigned FLASH_CYCLES = facs_pkg::FLASH_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [6:0] sw_addr,
  input wire logic sw_soft,
  input wire logic sw_lock,
  input wire logic sw_sim,
  input wire logic comm_active,
  output facs_pkg::facs_addr_t station_addr,
  output logic addr_valid,
  output logic restart,
  output facs_pkg::facs_layout_t layout,
  output logic [9:0] bar_seg,
  output logic bar_under,
  output logic bar_over,
  output logic caution_sym,
  output logic comm_sym,
  output logic lock_sym,
  output facs_pkg::facs_unit_t unit_sel,
  output logic [15:0] numeric,
  output logic [1:0] status_chan,
  output logic status_blank
);
  import facs_pkg::*;

  function automatic logic facs_valid(input facs_addr_t a);
    facs_valid = (a <= ADDR_MAX_VALID);
  endfunction

  function automatic logic facs_sel_ok(input logic [7:0] s);
    facs_sel_ok = (s == SEL_MAKER) || (s == SEL_PROF4) || (s == SEL_PROF1) || (s == SEL_PROF2);
  endfunction

  function automatic logic [9:0] facs_bar_fill(input logic [6:0] pct);
    logic [9:0] f;
    f = 10'h000;
    for (int i = 0; i < BAR_SEGS; i++) begin
      f[i] = (int'(pct) >= (i + 1) * BAR_STEP_PCT);
    end
    facs_bar_fill = f;
  endfunction

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  logic [9:0] sw_meta_r;
  logic [9:0] sw_sync_r;
  logic [9:0] sw_stable_r;
  logic [9:0] sw_seen_r;
  logic [31:0] deb_cnt_r;
  logic soft_prev_r;
  facs_state_t state_r;
  logic [31:0] rst_cnt_r;
  logic mode_soft_r;
  facs_addr_t station_addr_r;
  logic restart_r;
  logic refused_r;
  logic blocked_r;
  logic [7:0] ident_r;
  logic [15:0] param_r;
  logic [15:0] disp_val_r;
  logic [31:0] disp_cfg_r;
  logic [31:0] flash_cnt_r;
  logic flash_on_r;
  logic [31:0] reg_rdata_r;
  logic [31:0] rdata_nxt;
  facs_layout_t layout_r;
  logic [9:0] bar_seg_r;
  logic bar_under_r;
  logic bar_over_r;
  logic caution_r;
  logic comm_r;
  logic lock_r;
  facs_unit_t unit_r;
  logic [15:0] numeric_r;
  logic [1:0] chan_r;
  logic blank_r;
  logic addr_valid_r;

  logic wr_slave_add;
  logic wr_ident;
  logic wr_param;
  logic wr_status;
  logic err_act;
  logic diag_act;
  logic soft_stable;
  logic lock_stable;
  facs_addr_t new_addr;

  assign wr_slave_add = reg_wr && (reg_addr == REG_SLAVE_ADD);
  assign wr_ident = reg_wr && (reg_addr == REG_IDENT);
  assign wr_param = reg_wr && (reg_addr == REG_PARAM);
  assign wr_status = reg_wr && (reg_addr == REG_STATUS);
  assign err_act = disp_cfg_r[CFG_ERR_BIT];
  assign diag_act = disp_cfg_r[CFG_ERR_BIT] | disp_cfg_r[CFG_WARN_BIT];
  assign soft_stable = sw_stable_r[SW_SOFT_BIT];
  assign lock_stable = sw_stable_r[SW_LOCK_BIT];
  assign new_addr = reg_wdata[6:0];

  // Two-stage synchroniser; only the second stage is read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sw_meta_r <= SW_RESET;
      sw_sync_r <= SW_RESET;
    end else begin
      sw_meta_r <= {sw_sim, sw_lock, sw_soft, sw_addr};
      sw_sync_r <= sw_meta_r;
    end
  end

  // Whole bank debounced as one; any bounce restarts the settle time
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      deb_cnt_r <= 32'h0000_0000;
      sw_seen_r <= SW_RESET;
      sw_stable_r <= SW_RESET;
    end else begin
      sw_seen_r <= sw_sync_r;
      if ((sw_sync_r != sw_seen_r) || (sw_sync_r == sw_stable_r)) begin
        deb_cnt_r <= 32'h0000_0000;
      end else if (deb_cnt_r >= DEBOUNCE_CYCLES - 1) begin
        deb_cnt_r <= 32'h0000_0000;
        sw_stable_r <= sw_sync_r;
      end else begin
        deb_cnt_r <= deb_cnt_r + 32'h0000_0001;
      end
    end
  end

  // Restart sequencer; a further mode change during the wait reloads the delay
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      soft_prev_r <= SW_RESET[SW_SOFT_BIT];
      state_r <= FACS_ST_IDLE;
      rst_cnt_r <= 32'h0000_0000;
    end else begin
      soft_prev_r <= soft_stable;
      if (soft_stable != soft_prev_r) begin
        state_r <= FACS_ST_WAIT;
        rst_cnt_r <= 32'h0000_0000;
      end else begin
        case (state_r)
          FACS_ST_IDLE: begin
            rst_cnt_r <= 32'h0000_0000;
          end
          FACS_ST_WAIT: begin
            if (rst_cnt_r >= RESTART_CYCLES - 1) begin
              state_r <= FACS_ST_RESTART;
            end else begin
              rst_cnt_r <= rst_cnt_r + 32'h0000_0001;
            end
          end
          FACS_ST_RESTART: begin
            state_r <= FACS_ST_IDLE;
            rst_cnt_r <= 32'h0000_0000;
          end
          default: begin
            state_r <= FACS_ST_IDLE;
          end
        endcase
      end
    end
  end

  // Station address: taken at restart, or by telegram in software mode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_soft_r <= 1'b1;
      station_addr_r <= ADDR_DEFAULT;
      restart_r <= 1'b0;
    end else begin
      restart_r <= (state_r == FACS_ST_RESTART);
      if (state_r == FACS_ST_RESTART) begin
        mode_soft_r <= soft_stable;
        if (soft_stable) begin
          station_addr_r <= ADDR_DEFAULT;
        end else begin
          station_addr_r <= sw_stable_r[6:0];
        end
      end else if (wr_slave_add && mode_soft_r && facs_valid(new_addr)) begin
        station_addr_r <= new_addr;
      end
    end
  end

  // Sticky refusal flags; a new event beats a clear in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      refused_r <= 1'b0;
      blocked_r <= 1'b0;
    end else begin
      if (wr_slave_add && (!mode_soft_r || !facs_valid(new_addr))) begin
        refused_r <= 1'b1;
      end else if (wr_status && reg_wdata[STAT_REFUSED_BIT]) begin
        refused_r <= 1'b0;
      end
      if ((wr_ident || wr_param) && lock_stable) begin
        blocked_r <= 1'b1;
      end else if (wr_status && reg_wdata[STAT_BLOCKED_BIT]) begin
        blocked_r <= 1'b0;
      end
    end
  end

  // Parameters, blocked while the write lock is ON
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ident_r <= SEL_RESET;
      param_r <= PARAM_RESET;
    end else if (!lock_stable) begin
      if (wr_ident && facs_sel_ok(reg_wdata[7:0])) begin
        ident_r <= reg_wdata[7:0];
      end
      if (wr_param) begin
        param_r <= reg_wdata[15:0];
      end
    end
  end

  // Display data from the measurement side; not write protected
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      disp_val_r <= 16'h0000;
      disp_cfg_r <= 32'h0000_0000;
    end else begin
      if (reg_wr && (reg_addr == REG_DISP_VAL)) begin
        disp_val_r <= reg_wdata[15:0];
      end
      if (reg_wr && (reg_addr == REG_DISP_CFG)) begin
        disp_cfg_r <= reg_wdata;
      end
    end
  end

  // Flash phase generator, free running
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flash_cnt_r <= 32'h0000_0000;
      flash_on_r <= 1'b1;
    end else if (flash_cnt_r >= FLASH_CYCLES - 1) begin
      flash_cnt_r <= 32'h0000_0000;
      flash_on_r <= ~flash_on_r;
    end else begin
      flash_cnt_r <= flash_cnt_r + 32'h0000_0001;
    end
  end

  // Layout from selector
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      layout_r <= FACS_LAYOUT_MAKER;
    end else begin
      case (ident_r)
        SEL_PROF4: layout_r <= FACS_LAYOUT_PROF4;
        SEL_PROF1: layout_r <= FACS_LAYOUT_PROF1;
        SEL_PROF2: layout_r <= FACS_LAYOUT_PROF2;
        default: layout_r <= FACS_LAYOUT_MAKER;
      endcase
    end
  end

  // Local display drivers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bar_seg_r <= 10'h000;
      bar_under_r <= 1'b0;
      bar_over_r <= 1'b0;
      caution_r <= 1'b0;
      comm_r <= 1'b0;
      lock_r <= 1'b0;
      unit_r <= FACS_UNIT_K;
      numeric_r <= 16'h0000;
      chan_r <= 2'h0;
      blank_r <= 1'b0;
      addr_valid_r <= 1'b0;
    end else begin
      // Whole bar including range markers blinks so an error is visible at a glance
      if (err_act && !flash_on_r) begin
        bar_seg_r <= 10'h000;
        bar_under_r <= 1'b0;
        bar_over_r <= 1'b0;
      end else begin
        bar_seg_r <= facs_bar_fill(disp_cfg_r[CFG_PCT_LSB +: 7]);
        bar_under_r <= disp_cfg_r[CFG_UNDER_BIT];
        bar_over_r <= disp_cfg_r[CFG_OVER_BIT];
      end
      caution_r <= diag_act;
      comm_r <= comm_active;
      lock_r <= lock_stable;
      unit_r <= facs_unit_t'(disp_cfg_r[CFG_UNIT_LSB +: 2]);
      numeric_r <= diag_act ? disp_cfg_r[CFG_DIAG_LSB +: 16] : disp_val_r;
      chan_r <= diag_act ? disp_cfg_r[CFG_CHAN_LSB +: 2] : 2'h0;
      blank_r <= diag_act && (disp_cfg_r[CFG_CHAN_LSB +: 2] == 2'h0);
      addr_valid_r <= facs_valid(station_addr_r);
    end
  end

  // Read mux; unmapped offsets read zero. Simulation switch is reported only.
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (reg_addr)
      REG_STATUS: begin
        rdata_nxt[STAT_ADDR_LSB +: 7] = station_addr_r;
        rdata_nxt[STAT_MODE_BIT] = mode_soft_r;
        rdata_nxt[STAT_VALID_BIT] = facs_valid(station_addr_r);
        rdata_nxt[STAT_PEND_BIT] = (state_r != FACS_ST_IDLE);
        rdata_nxt[STAT_LOCK_BIT] = lock_stable;
        rdata_nxt[STAT_SIM_BIT] = sw_stable_r[SW_SIM_BIT];
        rdata_nxt[STAT_REFUSED_BIT] = refused_r;
        rdata_nxt[STAT_BLOCKED_BIT] = blocked_r;
        rdata_nxt[STAT_LAYOUT_LSB +: 2] = layout_r;
      end
      REG_SLAVE_ADD: rdata_nxt[6:0] = station_addr_r;
      REG_IDENT: rdata_nxt[7:0] = ident_r;
      REG_DISP_VAL: rdata_nxt[15:0] = disp_val_r;
      REG_DISP_CFG: rdata_nxt = disp_cfg_r;
      REG_PARAM: rdata_nxt[15:0] = param_r;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_r <= 32'h0000_0000;
    end else begin
      reg_rdata_r <= reg_rd ? rdata_nxt : 32'h0000_0000;
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign station_addr = station_addr_r;
  assign addr_valid = addr_valid_r;
  assign restart = restart_r;
  assign layout = layout_r;
  assign bar_seg = bar_seg_r;
  assign bar_under = bar_under_r;
  assign bar_over = bar_over_r;
  assign caution_sym = caution_r;
  assign comm_sym = comm_r;
  assign lock_sym = lock_r;
  assign unit_sel = unit_r;
  assign numeric = numeric_r;
  assign status_chan = chan_r;
  assign status_blank = blank_r;

  hw_addr_take_a: assert property (
    (state_r == FACS_ST_RESTART) && !soft_stable |=> station_addr_r == $past(sw_stable_r[6:0])
  ) else $error("hardware address not taken at restart");

  soft_default_a: assert property (
    (state_r == FACS_ST_RESTART) && soft_stable |=> station_addr_r == ADDR_DEFAULT && mode_soft_r
  ) else $error("default address not taken at restart");

  restart_delay_a: assert property (
    (state_r == FACS_ST_WAIT) && (rst_cnt_r < RESTART_CYCLES - 1) && (soft_stable == soft_prev_r)
      |=> state_r != FACS_ST_RESTART
  ) else $error("restart before delay elapsed");

  hw_refuse_a: assert property (
    wr_slave_add && !mode_soft_r && (state_r != FACS_ST_RESTART)
      |=> $stable(station_addr_r) && refused_r
  ) else $error("address changed in hardware mode");

  sw_accept_a: assert property (
    wr_slave_add && mode_soft_r && (new_addr <= ADDR_MAX_VALID) && (state_r != FACS_ST_RESTART)
      |=> station_addr_r == $past(new_addr)
  ) else $error("telegram address not accepted");

  lock_block_a: assert property (
    (wr_ident || wr_param) && lock_stable |=> $stable(ident_r) && $stable(param_r) && blocked_r
  ) else $error("parameter write passed the lock");

  restart_pulse_a: assert property (
    restart_r |-> !$past(restart_r) ##1 !restart_r
  ) else $error("restart pulse not one cycle");

  caution_sym_a: assert property (
    ##1 caution_r == $past(diag_act)
  ) else $error("caution symbol mismatch");

  numeric_diag_a: assert property (
    diag_act && $stable(disp_cfg_r) |=> numeric_r == $past(disp_cfg_r[CFG_DIAG_LSB +: 16])
  ) else $error("diagnostics not shown");

  bar_flash_a: assert property (
    err_act && !flash_on_r |=> bar_seg_r == 10'h000
  ) else $error("bar not blanked while flashing");

  lock_comm_a: assert property (
    ##1 (lock_r == $past(lock_stable)) && (comm_r == $past(comm_active))
  ) else $error("lock or communication symbol mismatch");
endmodule

// File: tb/facs_master_model.sv
`timescale 1ns/1ps
// Bus master station model: register telegrams and link activity
module facs_master_model (
  input wire logic clock,
  input wire logic [31:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic comm_active
);
  import facs_pkg::*;
  // Idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    comm_active = 1'b0;
  end
  // One-cycle write; address and data scrambled after release so stale values never help
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // Read data only stand in the cycle after the strobe
  task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
  // Address telegram; callers stay in the operating range unless testing refusal
  task automatic send_addr(input logic [6:0] a);
    write_reg(REG_SLAVE_ADD, {25'h000_0000, a});
  endtask
  // Link activity level
  task automatic set_comm(input logic on);
    @(posedge clock);
    comm_active <= on;
  endtask
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", nm, ex, got); end end
module testbench;
  import facs_pkg::*;
  localparam int unsigned RST_C = 20;
  localparam int unsigned DEB_C = 4;
  localparam int unsigned FL_C = 4;
  typedef struct packed {
    logic [31:0] cfg;
    logic [9:0] bar;
    logic [2:0] flg;
    logic [1:0] chan;
    logic blank;
    logic [15:0] num;
  } facs_row_t;
  logic clock;
  logic rst_n;
  logic [6:0] sw_addr;
  logic sw_soft;
  logic sw_lock;
  logic sw_sim;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic comm_active;
  logic [31:0] reg_rdata;
  facs_addr_t station_addr;
  logic addr_valid;
  logic restart;
  facs_layout_t layout;
  logic [9:0] bar_seg;
  logic bar_under;
  logic bar_over;
  logic caution_sym;
  logic comm_sym;
  logic lock_sym;
  facs_unit_t unit_sel;
  logic [15:0] numeric;
  logic [1:0] status_chan;
  logic status_blank;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;
  // Flags column: under, over, caution
  facs_row_t rows [6] = '{
    '{32'h0000_0000, 10'h000, 3'h0, 2'h0, 1'b0, 16'h0123},
    '{32'h0000_0509, 10'h000, 3'h4, 2'h0, 1'b0, 16'h0123},
    '{32'h0000_0a0a, 10'h001, 3'h2, 2'h0, 1'b0, 16'h0123},
    '{32'hbeef_ac37, 10'h01f, 3'h1, 2'h2, 1'b0, 16'hbeef},
    '{32'h0042_2064, 10'h3ff, 3'h1, 2'h0, 1'b1, 16'h0042},
    '{32'h1111_c063, 10'h1ff, 3'h0, 2'h0, 1'b0, 16'h0123}};
  facs_master_model mm (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .comm_active(comm_active));
  facs_config_select #(.RESTART_CYCLES(RST_C), .DEBOUNCE_CYCLES(DEB_C), .FLASH_CYCLES(FL_C))
    dut_u (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sw_addr(sw_addr),
    .sw_soft(sw_soft), .sw_lock(sw_lock), .sw_sim(sw_sim), .comm_active(comm_active),
    .station_addr(station_addr), .addr_valid(addr_valid), .restart(restart),
    .layout(layout), .bar_seg(bar_seg), .bar_under(bar_under), .bar_over(bar_over),
    .caution_sym(caution_sym), .comm_sym(comm_sym), .lock_sym(lock_sym),
    .unit_sel(unit_sel), .numeric(numeric), .status_chan(status_chan),
    .status_blank(status_blank));
  // 10 MHz clock
  always #50 clock = ~clock;
  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  // Bounded wait for the restart pulse; n reaches lim when none came
  task automatic wait_restart(input int lim, output int n);
    n = 0;
    while (restart !== 1'b1 && n < lim) begin
      step(1);
      n++;
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    logic [31:0] d;
    int n;
    int on;
    int off;
    logic [7:0] sel [5] = '{8'h00, 8'h81, 8'h05, 8'h82, 8'h01};
    facs_layout_t lay [5] = '{FACS_LAYOUT_PROF4, FACS_LAYOUT_PROF1, FACS_LAYOUT_PROF1,
      FACS_LAYOUT_PROF2, FACS_LAYOUT_MAKER};
    // Pins start idle, mode switch ON as delivered
    clock = 1'b0;
    rst_n = 1'b0;
    sw_addr = 7'h00;
    sw_soft = 1'b1;
    sw_lock = 1'b0;
    sw_sim = 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    step(2);
    // Table of display settings
    mm.write_reg(REG_DISP_VAL, 32'h0000_0123);
    foreach (rows[i]) begin
      mm.write_reg(REG_DISP_CFG, rows[i].cfg);
      step(3);
      `CHK("bar", rows[i].bar, bar_seg)
      `CHK("under over", rows[i].flg[2:1], {bar_under, bar_over})
      `CHK("caution", rows[i].flg[0], caution_sym)
      `CHK("numeric", rows[i].num, numeric)
      `CHK("chan", rows[i].chan, status_chan)
      `CHK("blank", rows[i].blank, status_blank)
      `CHK("unit", facs_unit_t'(rows[i].cfg[11:10]), unit_sel)
    end
    $display("test display table done");
    // Defaults after reset (rows never touch addressing)
    `CHK("addr", 7'd126, station_addr)
    `CHK("valid", 1'b0, addr_valid)
    `CHK("layout", FACS_LAYOUT_MAKER, layout)
    mm.read_reg(REG_IDENT, d);
    `CHK("ident", 32'h0000_0001, d)
    mm.read_reg(8'h40, d);
    `CHK("unmapped", 32'h0000_0000, d)
    $display("test reset values done");
    // Error makes the bar flash, caution lit
    mm.write_reg(REG_DISP_CFG, 32'h0000_1132);
    step(3);
    `CHK("caution err", 1'b1, caution_sym)
    on = 0;
    off = 0;
    for (int i = 0; i < 16; i++) begin
      on += (bar_seg === 10'h01f && bar_under === 1'b1);
      off += (bar_seg === 10'h000 && bar_under === 1'b0);
      step(1);
    end
    `CHK("flash", 1'b1, (on > 0 && off > 0 && on + off == 16))
    mm.write_reg(REG_DISP_CFG, 32'h0000_0000);
    $display("test flash done");
    // Selector codes; an unsupported one leaves the layout alone
    foreach (sel[i]) begin
      mm.write_reg(REG_IDENT, {24'h00_0000, sel[i]});
      step(3);
      `CHK("layout sel", lay[i], layout)
    end
    $display("test selectors done");
    mm.set_comm(1'b1);
    step(2);
    `CHK("comm on", 1'b1, comm_sym)
    mm.set_comm(1'b0);
    step(2);
    `CHK("comm off", 1'b0, comm_sym)
    $display("test comm done");
    // Software addressing: valid telegram taken, reserved ones refused
    mm.send_addr(7'd37);
    step(3);
    `CHK("soft addr", 7'd37, station_addr)
    `CHK("valid", 1'b1, addr_valid)
    mm.send_addr(7'd126);
    mm.send_addr(7'd127);
    step(3);
    `CHK("refused addr", 7'd37, station_addr)
    mm.read_reg(REG_STATUS, d);
    `CHK("refused flag", 1'b1, d[STAT_REFUSED_BIT])
    $display("test soft addressing done");
    // Write lock blocks parameter writes
    @(posedge clock) sw_lock <= 1'b1;
    step(12);
    `CHK("lock sym", 1'b1, lock_sym)
    mm.write_reg(REG_PARAM, 32'h0000_1234);
    mm.read_reg(REG_PARAM, d);
    `CHK("param locked", 32'h0000_0000, d)
    mm.read_reg(REG_STATUS, d);
    `CHK("blocked flag", 1'b1, d[STAT_BLOCKED_BIT])
    @(posedge clock) sw_lock <= 1'b0;
    step(12);
    `CHK("lock sym off", 1'b0, lock_sym)
    mm.write_reg(REG_PARAM, 32'h0000_00ab);
    mm.read_reg(REG_PARAM, d);
    `CHK("param", 32'h0000_00ab, d)
    $display("test lock done");
    // Short mode glitch under simulation switch: no restart, no change
    @(posedge clock) sw_sim <= 1'b1;
    @(posedge clock) sw_soft <= 1'b0;
    @(posedge clock);
    @(posedge clock) sw_soft <= 1'b1;
    wait_restart(40, n);
    `CHK("no restart", 40, n)
    `CHK("addr kept", 7'd37, station_addr)
    $display("test glitch done");
    // Mode ON to OFF: delayed restart with switch address 32+16+1
    @(posedge clock) begin
      sw_addr <= 7'h31;
      sw_soft <= 1'b0;
    end
    wait_restart(100, n);
    `CHK("delay", 1'b1, (n > RST_C && n < RST_C + 12))
    `CHK("hw addr", 7'(32 + 16 + 1), station_addr)
    mm.send_addr(7'd10);
    step(3);
    `CHK("hw refuse", 7'(32 + 16 + 1), station_addr)
    $display("test hardware mode done");
    // Mode OFF to ON: back to the commissioning address, telegrams accepted
    @(posedge clock) sw_soft <= 1'b1;
    wait_restart(100, n);
    `CHK("delay", 1'b1, (n > RST_C && n < RST_C + 12))
    `CHK("default addr", 7'd126, station_addr)
    step(2);
    `CHK("invalid", 1'b0, addr_valid)
    mm.send_addr(7'd5);
    step(3);
    `CHK("soft again", 7'd5, station_addr)
    $display("test soft mode done");
    // Mid-run reset: factory address and software mode again
    @(posedge clock) rst_n <= 1'b0;
    step(2);
    `CHK("rst addr", 7'd126, station_addr)
    @(posedge clock) rst_n <= 1'b1;
    mm.read_reg(REG_STATUS, d);
    `CHK("rst mode", 1'b1, d[STAT_MODE_BIT])
    $display("test mid reset done");
    test_done();
  end
endmodule
